// ===== hdl/twb_bus_ctrl.v
// two-wire bus controller: apb register file, bus monitor, master sequencer and byte engine
//
// Decided for this implementation: the register addresses and register access over APB.
`include "twb_regs.vh"
module twb_bus_ctrl #(
  parameter SCL_HALF = `TWB_SCL_HALF_CYC
) (
  input wire clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe
);
  // ----------------------------------------
  // master sequencer states, and the decode value for an unmapped address
  // ----------------------------------------
  localparam [2:0] M_IDLE = 3'd0;
  localparam [2:0] M_START = 3'd1;
  localparam [2:0] M_RUN = 3'd2;
  localparam [2:0] M_STOP = 3'd3;
  localparam [2:0] M_RS = 3'd4;
  localparam [2:0] R_NONE = 3'd7;

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg en_reg, ie_reg, mst_reg, tx_reg, ack_drive_n_reg;
  reg gcen_reg, wide_reg;
  reg [2:0] ahi_reg;
  reg [7:0] saddr_reg;
  reg done_reg, aas_reg, busy_reg, arb_lost_flag_reg, srw_reg, evt_reg, ack_received_n_reg;
  reg [7:0] rx_reg, sh_reg;
  reg [3:0] cnt_reg;
  reg act_reg, hold_reg, adr_reg, wstg_reg, wpend_reg, slv_reg;
  reg [2:0] mph_reg;
  reg [1:0] stp_reg;
  reg gen_reg, sda_oe_reg, scl_oe_reg;
  reg [31:0] prdata_reg;
  reg pready_reg, pslverr_reg, irq_reg;
  reg scl_d_reg, sda_d_reg;
  reg [7:0] rmux;
  wire [1:0] pin_f;
  wire tick;

  // ----------------------------------------
  // address decode, shared by setup and access phases
  // ----------------------------------------
  function [2:0] dec;
    input [7:0] a;
    begin
      case (a)
        `TWB_OFF_CTRL1: dec = 3'd0;
        `TWB_OFF_STAT: dec = 3'd1;
        `TWB_OFF_DATA: dec = 3'd2;
        `TWB_OFF_CTRL2: dec = 3'd3;
        `TWB_OFF_SADDR: dec = 3'd4;
        default: dec = R_NONE;
      endcase
    end
  endfunction

  // writes and read side effects happen only at the completing edge
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready_reg;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire wr_c1 = wr & (dec(paddr) == 3'd0);
  wire wr_st = wr & (dec(paddr) == 3'd1);
  wire wr_dat = wr & (dec(paddr) == 3'd2);
  wire rd_dat = rd & (dec(paddr) == 3'd2);
  wire wr_c2 = wr & (dec(paddr) == 3'd3);
  wire wr_sa = wr & (dec(paddr) == 3'd4);

  // ----------------------------------------
  // pin synchronisation and bus condition detection
  // ----------------------------------------
  twb_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .din({scl_in, sda_in}),
    .dout(pin_f)
  );

  wire scl_f = pin_f[1];
  wire sda_f = pin_f[0];
  wire start_det = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  wire stop_det = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
  wire rise = ~scl_d_reg & scl_f;
  wire fall = scl_d_reg & ~scl_f;

  // previous filtered levels for edge finding
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
    end
  end

  // ----------------------------------------
  // derived control terms
  // ----------------------------------------
  // the enabling write itself counts as enabled, so enable and master select may come together
  wire en_go = en_reg | (wr_c1 & pwdata[`TWB_C1_EN]);
  wire mst_set = wr_c1 & pwdata[`TWB_C1_MST] & ~mst_reg;
  wire mst_clr = wr_c1 & ~pwdata[`TWB_C1_MST] & mst_reg;
  wire rs_req = wr_c1 & pwdata[`TWB_C1_REPEAT_START_STROBE];
  // slave is receiving its address, so direction is forced to receive then
  wire tx_eff = tx_reg & ~adr_reg;
  // transfer may launch only when the engine is parked on a byte boundary
  wire go_ok = en_reg & hold_reg & (mst_reg ? (mph_reg == M_RUN) : slv_reg);
  wire launch_tx = wr_dat & tx_reg & go_ok;
  wire launch_rx = rd_dat & ~tx_reg & go_ok;
  wire bit_rise = act_reg & rise & (cnt_reg < 4'd8);
  // we released sda for a one but the bus shows zero
  wire arb_bit = bit_rise & mst_reg & tx_eff & ~sda_oe_reg & ~sda_f;
  // repeat outside a parked master byte boundary is a misuse
  wire rs_bad = rs_req & mst_reg & ~((mph_reg == M_RUN) & hold_reg);
  wire lose = en_go & ((mst_set & busy_reg & (mph_reg == M_IDLE)) | rs_bad | arb_bit);
  // address comparison for the byte now in the shifter
  wire gcall = gcen_reg & (sh_reg == `TWB_GCALL_ADDR) & ~wstg_reg;
  wire wide1 = sh_reg[7:1] == {`TWB_WIDE_PREFIX, ahi_reg[1:0]};
  wire hit7 = sh_reg[7:1] == saddr_reg[7:1];
  wire hitw = wstg_reg ? (sh_reg == saddr_reg) : (wide1 & ~sh_reg[0]);
  wire hit = (wide_reg ? hitw : hit7) | gcall;
  // timer runs in every master phase except while parked or waiting on a stretched scl
  wire run = en_reg & (mph_reg != M_IDLE) & ~hold_reg & (gen_reg | scl_f);

  twb_tick #(
    .HALF(SCL_HALF)
  ) u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .run(run),
    .tick(tick)
  );

  // ----------------------------------------
  // software-owned control registers
  // ----------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_reg <= 1'b0;
      ie_reg <= 1'b0;
      tx_reg <= 1'b0;
      ack_drive_n_reg <= 1'b0;
      gcen_reg <= 1'b0;
      wide_reg <= 1'b0;
      ahi_reg <= 3'h0;
      saddr_reg <= `TWB_RST_SADDR;
    end else begin
      if (wr_c1) begin
        en_reg <= pwdata[`TWB_C1_EN];
        ie_reg <= pwdata[`TWB_C1_IE];
        tx_reg <= pwdata[`TWB_C1_TX];
        ack_drive_n_reg <= pwdata[`TWB_C1_ACK_DRIVE_N];
      end
      if (wr_c2) begin
        gcen_reg <= pwdata[`TWB_C2_GCEN];
        wide_reg <= pwdata[`TWB_C2_WIDE];
        ahi_reg <= pwdata[2:0];
      end
      if (wr_sa)
        saddr_reg <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // read mux; strobe bit and gaps read zero
  // ----------------------------------------
  always @* begin
    case (dec(paddr))
      3'd0: rmux = {en_reg, ie_reg, mst_reg, tx_reg, ack_drive_n_reg, 3'b000};
      3'd1: rmux = {done_reg, aas_reg, busy_reg, arb_lost_flag_reg, 1'b0, srw_reg, evt_reg, ack_received_n_reg};
      3'd2: rmux = rx_reg;
      3'd3: rmux = {gcen_reg, wide_reg, 3'b000, ahi_reg};
      3'd4: rmux = saddr_reg;
      default: rmux = 8'h00;
    endcase
  end

  // ----------------------------------------
  // apb answer: ready in the first access cycle, data captured at setup
  // ----------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      irq_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & (dec(paddr) == R_NONE);
      if (setup & ~pwrite)
        prdata_reg <= {24'h000000, rmux};
      irq_reg <= evt_reg & ie_reg;
    end
  end

  // ----------------------------------------
  // bus engine: flags, master sequencer, byte shifter
  // ----------------------------------------
  // clears come first in the block so a same-cycle set wins
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mst_reg <= 1'b0;
      done_reg <= 1'b0;
      aas_reg <= 1'b0;
      busy_reg <= 1'b0;
      arb_lost_flag_reg <= 1'b0;
      srw_reg <= 1'b0;
      evt_reg <= 1'b0;
      ack_received_n_reg <= 1'b0;
      rx_reg <= `TWB_RST_DATA;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      act_reg <= 1'b0;
      hold_reg <= 1'b0;
      adr_reg <= 1'b0;
      wstg_reg <= 1'b0;
      wpend_reg <= 1'b0;
      slv_reg <= 1'b0;
      mph_reg <= M_IDLE;
      stp_reg <= 2'd0;
      gen_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      if (wr_st & pwdata[`TWB_ST_ARB_LOST_FLAG])
        arb_lost_flag_reg <= 1'b0;
      if (wr_st & pwdata[`TWB_ST_EVT])
        evt_reg <= 1'b0;
      if (wr_c1)
        aas_reg <= 1'b0;
      if ((wr_dat & tx_reg) | (rd_dat & ~tx_reg))
        done_reg <= 1'b0;
      if (start_det)
        busy_reg <= 1'b1;
      if (stop_det)
        busy_reg <= 1'b0;
      if (!en_go) begin
        // disabled: release the bus and park everything
        mst_reg <= 1'b0;
        mph_reg <= M_IDLE;
        act_reg <= 1'b0;
        hold_reg <= 1'b0;
        slv_reg <= 1'b0;
        adr_reg <= 1'b0;
        gen_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
      end else begin
        // master sequencer
        case (mph_reg)
          M_IDLE: begin
            if (mst_set & ~busy_reg) begin
              mst_reg <= 1'b1;
              sda_oe_reg <= 1'b1;
              mph_reg <= M_START;
            end
          end
          M_START: begin
            if (tick) begin
              gen_reg <= 1'b1;
              hold_reg <= 1'b1;
              mph_reg <= M_RUN;
            end
          end
          M_RUN: begin
            if (mst_clr) begin
              // pull sda low under low scl, then release scl, then sda
              mst_reg <= 1'b0;
              sda_oe_reg <= 1'b1;
              hold_reg <= 1'b0;
              gen_reg <= 1'b1;
              act_reg <= 1'b0;
              stp_reg <= 2'd0;
              mph_reg <= M_STOP;
            end else if (rs_req & hold_reg) begin
              sda_oe_reg <= 1'b0;
              hold_reg <= 1'b0;
              gen_reg <= 1'b1;
              stp_reg <= 2'd0;
              mph_reg <= M_RS;
            end else if (tick & ~hold_reg) begin
              gen_reg <= ~gen_reg;
            end
          end
          M_STOP: begin
            if (tick) begin
              if (stp_reg == 2'd0) begin
                gen_reg <= 1'b0;
                stp_reg <= 2'd1;
              end else begin
                sda_oe_reg <= 1'b0;
                mph_reg <= M_IDLE;
              end
            end
          end
          M_RS: begin
            if (tick) begin
              case (stp_reg)
                2'd0: begin
                  gen_reg <= 1'b0;
                  stp_reg <= 2'd1;
                end
                2'd1: begin
                  sda_oe_reg <= 1'b1;
                  stp_reg <= 2'd2;
                end
                default: begin
                  gen_reg <= 1'b1;
                  hold_reg <= 1'b1;
                  mph_reg <= M_RUN;
                end
              endcase
            end
          end
          default: mph_reg <= M_IDLE;
        endcase
        // launch a byte from a parked boundary; first bit goes out at once
        if (launch_tx | launch_rx) begin
          hold_reg <= 1'b0;
          act_reg <= 1'b1;
          cnt_reg <= 4'h0;
          sh_reg <= launch_tx ? pwdata[7:0] : 8'hff;
          sda_oe_reg <= launch_tx & ~pwdata[7];
        end
        // a start seen while not master begins an address reception
        if (start_det & ~mst_reg) begin
          act_reg <= 1'b1;
          adr_reg <= 1'b1;
          cnt_reg <= 4'h0;
          wstg_reg <= 1'b0;
          wpend_reg <= 1'b0;
          slv_reg <= 1'b0;
          hold_reg <= 1'b0;
          sda_oe_reg <= 1'b0;
        end
        if (stop_det & ~mst_reg) begin
          act_reg <= 1'b0;
          slv_reg <= 1'b0;
          hold_reg <= 1'b0;
        end
        // sample data bits on scl rising
        if (bit_rise) begin
          sh_reg <= {sh_reg[6:0], sda_f};
          cnt_reg <= cnt_reg + 4'h1;
        end
        // ninth clock: sample the far end's acknowledge
        if (act_reg & rise & (cnt_reg == 4'd8)) begin
          cnt_reg <= 4'd9;
          if (tx_eff)
            ack_received_n_reg <= sda_f;
        end
        // drive on scl falling
        if (act_reg & fall) begin
          if (cnt_reg < 4'd8) begin
            sda_oe_reg <= tx_eff & ~sh_reg[7];
          end else if (cnt_reg == 4'd8) begin
            if (adr_reg) begin
              if (hit) begin
                sda_oe_reg <= 1'b1;
                wpend_reg <= wide_reg & ~wstg_reg & ~gcall;
                srw_reg <= wstg_reg ? 1'b0 : sh_reg[0];
              end else begin
                // not for us: drop out of this transfer
                act_reg <= 1'b0;
                adr_reg <= 1'b0;
                sda_oe_reg <= 1'b0;
              end
            end else begin
              sda_oe_reg <= ~tx_eff & ~ack_drive_n_reg;
            end
          end else begin
            sda_oe_reg <= 1'b0;
            cnt_reg <= 4'h0;
            if (adr_reg & wpend_reg) begin
              // wide first byte accepted; keep receiving the low byte
              wstg_reg <= 1'b1;
              wpend_reg <= 1'b0;
            end else begin
              done_reg <= 1'b1;
              evt_reg <= 1'b1;
              hold_reg <= 1'b1;
              act_reg <= 1'b0;
              if (adr_reg) begin
                aas_reg <= 1'b1;
                slv_reg <= 1'b1;
                adr_reg <= 1'b0;
              end else if (~tx_eff) begin
                rx_reg <= sh_reg;
              end
            end
          end
        end
        // arbitration loss: release sda at once, no stop, back to slave
        if (lose) begin
          mst_reg <= 1'b0;
          mph_reg <= M_IDLE;
          arb_lost_flag_reg <= 1'b1;
          evt_reg <= 1'b1;
          gen_reg <= 1'b0;
          hold_reg <= 1'b0;
          act_reg <= 1'b0;
          sda_oe_reg <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // scl drive: master generator or byte-boundary stretch
  // ----------------------------------------
  // one cycle behind the engine; negligible against a half period of hundreds of cycles
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      scl_oe_reg <= 1'b0;
    else
      scl_oe_reg <= en_reg & (hold_reg | gen_reg);
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign scl_oe = scl_oe_reg;
  assign sda_oe = sda_oe_reg;
  // open drain: the driven level is always low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
endmodule

// ===== hdl/twb_regs.vh
// register map, field positions, reset values and timing counts of the two-wire controller
`ifndef TWB_REGS_VH
`define TWB_REGS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define TWB_OFF_CTRL1 8'h00
`define TWB_OFF_STAT 8'h04
`define TWB_OFF_DATA 8'h08
`define TWB_OFF_CTRL2 8'h0c
`define TWB_OFF_SADDR 8'h10
// ----------------------------------------
// control_one fields
// ----------------------------------------
`define TWB_C1_EN 7
`define TWB_C1_IE 6
`define TWB_C1_MST 5
`define TWB_C1_TX 4
`define TWB_C1_ACK_DRIVE_N 3
`define TWB_C1_REPEAT_START_STROBE 2
// ----------------------------------------
// status_flags fields
// ----------------------------------------
`define TWB_ST_DONE 7
`define TWB_ST_AAS 6
`define TWB_ST_BUSY 5
`define TWB_ST_ARB_LOST_FLAG 4
`define TWB_ST_SRW 2
`define TWB_ST_EVT 1
`define TWB_ST_ACK_RECEIVED_N 0
// ----------------------------------------
// control_two fields
// ----------------------------------------
`define TWB_C2_GCEN 7
`define TWB_C2_WIDE 6
// ----------------------------------------
// reset values and fixed address patterns
// ----------------------------------------
`define TWB_RST_CTRL1 8'h00
`define TWB_RST_CTRL2 8'h00
`define TWB_RST_SADDR 8'h00
`define TWB_RST_DATA 8'h00
`define TWB_WIDE_PREFIX 5'h1e
`define TWB_GCALL_ADDR 8'h00
// ----------------------------------------
// timing: scl half period in ns, converted to clk cycles (rounded up)
// ----------------------------------------
`define TWB_CLK_NS 10
`define TWB_SCL_HALF_NS 5000
`define TWB_SCL_HALF_CYC ((`TWB_SCL_HALF_NS + `TWB_CLK_NS - 1) / `TWB_CLK_NS)
`endif

// ===== hdl/twb_sync.v
// three-stage input synchroniser with agreement filter for bus pins
module twb_sync #(
  parameter WIDTH = 2
) (
  input wire clk,
  input wire rst_b,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  reg [WIDTH-1:0] out_reg;
  genvar i;

  // idle bus lines are pulled high, so all stages reset to one
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= {WIDTH{1'b1}};
      s2_reg <= {WIDTH{1'b1}};
      s3_reg <= {WIDTH{1'b1}};
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts only once stages two and three agree
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
          out_reg[i] <= 1'b1;
        else if (s2_reg[i] == s3_reg[i])
          out_reg[i] <= s3_reg[i];
      end
    end
  endgenerate

  assign dout = out_reg;
endmodule

// ===== hdl/twb_tick.v
// half-period timer for scl generation; pulses once per HALF cycles while run is high
module twb_tick #(
  parameter HALF = 500
) (
  input wire clk,
  input wire rst_b,
  input wire run,
  output wire tick
);
  localparam integer LAST_I = HALF - 1;
  localparam [15:0] LAST = LAST_I[15:0];
  reg [15:0] cnt_reg;
  reg tick_reg;

  // count restarts whenever run drops, so every phase gets a full half period
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (cnt_reg == LAST) begin
      cnt_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  assign tick = tick_reg;
endmodule

// ===== bench/twb_chk.sv
// port checker for the two-wire controller
`include "twb_regs.vh"
module twb_chk #(
  parameter SCL_HALF = 8
) (
  input wire clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire irq,
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ----------
  // shadow of control_one as software wrote it
  // ----------
  wire acc = psel && penable && pready;
  wire wr_c1 = acc && pwrite && paddr == `TWB_OFF_CTRL1;
  wire wr_dat = acc && pwrite && paddr == `TWB_OFF_DATA;
  reg [7:0] c1_reg;
  reg [7:0] c1_d_reg;
  reg d7_reg;
  // delayed copy covers the one-clock lag of the pin enables
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      c1_reg <= 8'h00;
      c1_d_reg <= 8'h00;
      d7_reg <= 1'b0;
    end else begin
      c1_d_reg <= c1_reg;
      if (wr_c1) c1_reg <= pwdata[7:0];
      if (wr_dat) d7_reg <= pwdata[7];
    end
  end
  // ----------
  // properties
  // ----------
  property p_zero_wait; psel && !penable |=> pready; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("access not answered");
  property p_unmapped; pready |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0); endproperty
  a_unmapped: assert property (p_unmapped) else $error("error response wrong");
  property p_repeat_start_strobe_zero; pready && !pwrite && paddr == `TWB_OFF_CTRL1 |-> !prdata[2]; endproperty
  a_repeat_start_strobe_zero: assert property (p_repeat_start_strobe_zero) else $error("repeat start bit read as one");
  property p_irq_gate; !c1_reg[6] && !c1_d_reg[6] |-> !irq; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
  property p_disabled; !c1_reg[7] && !c1_d_reg[7] |-> !sda_oe && !scl_oe; endproperty
  a_disabled: assert property (p_disabled) else $error("pins driven while disabled");
  property p_start; wr_c1 && pwdata[7] && pwdata[5] && !c1_reg[5] && scl_in && sda_in
    |=> ##[0:3] sda_oe && !scl_oe; endproperty
  a_start: assert property (p_start) else $error("no start after master select");
  property p_stop; wr_c1 && c1_reg[5] && c1_reg[7] && pwdata[7] && !pwdata[5]
    |=> ##[0:40] (sda_oe && !scl_oe) ##[1:20] (!sda_oe && !scl_oe); endproperty
  a_stop: assert property (p_stop) else $error("no stop after master clear");
  property p_msb_first; wr_dat && c1_reg[5] && c1_reg[4] |=> ##[0:2] sda_oe == !d7_reg; endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not msb");
endmodule
bind twb_bus_ctrl twb_chk #(.SCL_HALF(SCL_HALF)) twb_chk_inst (
  .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .irq, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe
);

// ===== bench/twb_peer.sv
// far-side slave model: acks bytes and keeps the last one seen
module twb_peer (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  output logic sda_oe,
  output logic [7:0] last_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] bit_cnt = 4'h0;
  logic [7:0] shift = 8'h00;
  initial sda_oe = 1'b0;
  // a start restarts the bit count
  always @(negedge sda) if (scl === 1'b1) bit_cnt = 4'h0;
  // data is only stable while scl is high
  always @(posedge scl) begin
    shift = {shift[6:0], sda};
    bit_cnt = bit_cnt + 4'h1;
  end
  // ack only in the ninth slot, released after it so the line floats high
  always @(negedge scl) begin
    sda_oe = 1'b0;
    if (bit_cnt == 4'h8) last_byte = shift;
    if (bit_cnt == 4'h8) sda_oe = ack_en;
    if (bit_cnt == 4'h9) bit_cnt = 4'h0;
  end
endmodule

// ===== bench/twb_bus_ctrl_tb_top.sv
// testbench for the two-wire controller
`include "twb_regs.vh"
module twb_bus_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic tb_scl_oe = 1'b0;
  logic tb_sda_oe = 1'b0;
  logic ack_en = 1'b1;
  logic [31:0] q;
  logic se;
  logic ack;
  logic [25:0] rows [0:10];
  logic [23:0] frm [0:3];
  wire [31:0] prdata;
  wire pready, pslverr, irq, scl_oe, sda_oe, peer_sda_oe;
  wire [7:0] peer_byte;
  integer err_total = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer i;
  // open-drain lines with pull-ups
  wire scl = ~scl_oe & ~tb_scl_oe;
  wire sda = ~sda_oe & ~peer_sda_oe & ~tb_sda_oe;
  always #5 clk = ~clk;
  twb_bus_ctrl #(.SCL_HALF(8)) twb_bus_ctrl_inst (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe)
  );
  twb_peer twb_peer_inst (.scl(scl), .sda(sda), .ack_en(ack_en), .sda_oe(peer_sda_oe), .last_byte(peer_byte));
  // ----------
  // tasks
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  // request held until pready is sampled high at a rising edge; read data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never reassigns psel in this time step
    @(posedge clk);
  endtask
  task automatic st(input logic [7:0] e);
    apb(1'b0, `TWB_OFF_STAT, 8'h00);
    chk(q, {24'h0, e});
  endtask
  // wait for irq (s=1) or a parked scl (s=0); the hang guard ends a wait that never finishes
  task automatic wait_sig(input logic s);
    while ((s ? irq : scl_oe) !== 1'b1) @(posedge clk);
  endtask
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  // outside master, 160 ns bit period; data moves mid-low, never with scl
  task automatic ext_byte(input logic [7:0] b, output logic a);
    integer k;
    for (k = 0; k < 9; k++) begin
      repeat (4) @(posedge clk);
      tb_sda_oe <= (k < 8) ? ~b[7 - k] : 1'b0;
      repeat (4) @(posedge clk);
      tb_scl_oe <= 1'b0;
      repeat (8) @(posedge clk);
      a = sda;
      tb_scl_oe <= 1'b1;
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results;
    end
  end
  // ----------
  // main sequence
  // ----------
  initial begin
    rows = '{{1'b0, `TWB_OFF_STAT, 16'h0, 1'b0}, {1'b0, `TWB_OFF_CTRL1, 16'h0, 1'b0},
      {1'b1, `TWB_OFF_CTRL2, 16'hff00, 1'b0}, {1'b0, `TWB_OFF_CTRL2, 16'h00c7, 1'b0},
      {1'b1, `TWB_OFF_CTRL1, 16'h5c00, 1'b0}, {1'b0, `TWB_OFF_CTRL1, 16'h0058, 1'b0},
      {1'b1, `TWB_OFF_STAT, 16'hff00, 1'b0}, {1'b0, `TWB_OFF_STAT, 16'h0000, 1'b0},
      {1'b0, 8'h14, 16'h0, 1'b1}, {1'b1, `TWB_OFF_SADDR, 16'h5400, 1'b0},
      {1'b0, `TWB_OFF_SADDR, 16'h0054, 1'b0}};
    frm = '{24'h0055e6, 24'h8000e2, 24'h005720, 24'h405520};
    @(posedge clk);
    do_reset;
    // register table, one row per access
    for (i = 0; i < 11; i++) begin
      apb(rows[i][25], rows[i][24:17], rows[i][16:9]);
      if (!rows[i][25]) chk(q, {24'h0, rows[i][8:1]});
      chk({31'h0, se}, {31'h0, rows[i][0]});
    end
    // master transmit: address byte, then a refused byte
    apb(1'b1, `TWB_OFF_CTRL1, 8'hf0);
    wait_sig(1'b0);
    apb(1'b1, `TWB_OFF_DATA, 8'ha6);
    wait_sig(1'b1);
    st(8'ha2);
    chk({24'h0, peer_byte}, 32'ha6);
    apb(1'b1, `TWB_OFF_STAT, 8'h02);
    ack_en <= 1'b0;
    apb(1'b1, `TWB_OFF_DATA, 8'h3c);
    st(8'h20);
    wait_sig(1'b1);
    st(8'ha3);
    apb(1'b0, `TWB_OFF_DATA, 8'h00);
    st(8'ha3);
    chk({24'h0, peer_byte}, 32'h3c);
    apb(1'b1, `TWB_OFF_CTRL1, 8'hc0);
    repeat (60) @(posedge clk);
    apb(1'b0, `TWB_OFF_STAT, 8'h00);
    chk(q & 32'h20, 32'h0);
    // addressed by an outside master: match, general call, mismatch
    for (i = 0; i < 4; i++) begin
      do_reset;
      apb(1'b1, `TWB_OFF_SADDR, 8'h54);
      apb(1'b1, `TWB_OFF_CTRL2, frm[i][23:16]);
      apb(1'b1, `TWB_OFF_CTRL1, 8'h80);
      tb_sda_oe <= 1'b1;
      repeat (8) @(posedge clk);
      tb_scl_oe <= 1'b1;
      ext_byte(frm[i][15:8], ack);
      chk({31'h0, ack}, {31'h0, ~frm[i][6]});
      repeat (6) @(posedge clk);
      st(frm[i][7:0]);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `TWB_OFF_CTRL1, {3'b100, frm[i][2], 4'h0});
      st({frm[i][7], 1'b0, frm[i][5:0]});
      apb(1'b1, `TWB_OFF_CTRL1, 8'h00);
      tb_sda_oe <= 1'b1;
      repeat (8) @(posedge clk);
      tb_scl_oe <= 1'b0;
      repeat (8) @(posedge clk);
      tb_sda_oe <= 1'b0;
      repeat (8) @(posedge clk);
    end
    // master select while another master holds the bus loses arbitration at once
    apb(1'b1, `TWB_OFF_CTRL1, 8'h80);
    tb_sda_oe <= 1'b1;
    repeat (8) @(posedge clk);
    apb(1'b1, `TWB_OFF_CTRL1, 8'ha0);
    st(8'h32);
    apb(1'b1, `TWB_OFF_STAT, 8'h10);
    st(8'h22);
    apb(1'b0, `TWB_OFF_CTRL1, 8'h00);
    chk(q, 32'h80);
    results;
  end
endmodule
